// File: core/fpd_pkg.sv
package fpd_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_DIGITS   = 8'h04;
  localparam logic [7:0] ADDR_CMD      = 8'h08;
  localparam logic [7:0] ADDR_TEXT_IN  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_READ_SEL = 8'h14;
  localparam logic [7:0] ADDR_READ_DAT = 8'h18;
  localparam logic [7:0] ADDR_MSG_LEN  = 8'h1C;

  // field positions
  localparam int CTRL_DISP_EN   = 0;
  localparam int CTRL_TEXT_UP   = 1;
  localparam int CTRL_TEXT_LO   = 2;
  localparam int CMD_MAIN_VIEW  = 0;
  localparam int CMD_SYS_LOCAL  = 1;
  localparam int CMD_MSG_START  = 2;
  localparam int CMD_WIN_LSB    = 8;
  localparam int TEXT_EOL       = 8;
  localparam int DIG_KIND_LSB   = 8;
  localparam int ST_REMOTE      = 0;
  localparam int ST_BUSY        = 1;
  localparam int ST_DIG_ERR     = 4;
  localparam int ST_LEN_ERR     = 5;
  localparam int ST_SYN_ERR     = 6;
  localparam int SEL_LINE       = 8;
  localparam int SEL_DEFINED    = 9;

  // line widths in characters
  localparam int UPPER_WIDTH = 20;
  localparam int LOWER_WIDTH = 32;

  // resolution codes: 4..7 give 3.5..6.5 digits
  localparam logic [2:0] DIG_MIN = 3'h4;
  localparam logic [2:0] DIG_DEF = 3'h6;
  localparam logic [2:0] DIG_MAX = 3'h7;

  // resolution keyword selector
  typedef enum logic [1:0] {
    DK_VALUE = 2'b00,
    DK_DEF   = 2'b01,
    DK_MIN   = 2'b10,
    DK_MAX   = 2'b11
  } fpd_dig_kind_t;

  // reset values
  localparam logic       RST_DISP_EN = 1'b1;
  localparam logic [2:0] RST_DIGITS  = DIG_DEF;

  // frozen notice shown while the display is disabled
  localparam logic [8*UPPER_WIDTH-1:0] NOTICE_UP = "REMOTE PANEL LOCKED ";
  localparam logic [8*LOWER_WIDTH-1:0] NOTICE_LO = "LOCAL KEY RETURNS TO PANEL      ";

  // ascii values the parser and readback use
  localparam logic [7:0] CH_SQUOTE = 8'h27;
  localparam logic [7:0] CH_DQUOTE = 8'h22;
  localparam logic [7:0] CH_HASH   = 8'h23;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_ONE    = 8'h31;
  localparam logic [7:0] CH_TWO    = 8'h32;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [7:0] CH_SPACE  = 8'h20;

  // message parser states
  typedef enum logic [2:0] {
    PS_IDLE  = 3'b000,
    PS_OPEN  = 3'b001,
    PS_QUOTE = 3'b010,
    PS_HASH  = 3'b011,
    PS_LEN   = 3'b100,
    PS_BODY  = 3'b101,
    PS_INDEF = 3'b110
  } fpd_parse_t;

endpackage : fpd_pkg

// File: core/fpd_msg_mem.sv
`timescale 1ns/1ps
// simple dual-port message store with registered read data
module fpd_msg_mem #(
  parameter int Width = 8,
  parameter int Depth = 64
) (
  input  wire logic                     clock,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(Depth)-1:0] wrAddr,
  input  wire logic [Width-1:0]         wrData,
  input  wire logic [$clog2(Depth)-1:0] rdAddr,
  output logic      [Width-1:0]         rdData
);

  logic [Width-1:0] store [Depth];

  if (Depth < 2 || Width < 1) begin : g_check
    $error("fpd_msg_mem needs Depth of at least 2");
  end

  // no reset on the array: contents are only trusted below the stored length
  always_ff @(posedge clock) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end

endmodule : fpd_msg_mem

// File: core/fpd_display_cmd.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - codes 4..7 mean 3.5..6.5 digits
// - fractional resolution rounded to nearest integer
// - default keyword and query give 5.5
// - min 3.5, max 6.5, both readable
// - enable 0 off, 1 on, readable
// - disabled: frozen notice, keys blocked except two
// - enable or local restores normal display
// - blink map: 20 upper, 32 lower
// - blink flag 1 blinking, 0 steady
// - main view command leaves menu
// - display read returns shown line content
// - window 1 or default upper, 2 lower
// - quoted, indefinite and definite block forms
// - spaces count; 20/32 limits; longer errors
// - indefinite block swallows rest of line
// - text mode shows or removes message
// - bus local cancels message and mode
// - serial local command or key cancels
// - message and mode readable
module fpd_display_cmd #(
  parameter int NumKeys = 8
) (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                localKey,
  input  wire logic                busGoToLocal,
  input  wire logic                outputOffKey,
  input  wire logic [NumKeys-1:0]  panelKeys,
  output logic      [NumKeys-1:0]  panelKeysOut,
  output logic                     outputOffOut,
  output logic                     returnMainView,
  output logic                     liveLine,
  output logic      [4:0]          livePos,
  input  wire logic [7:0]          liveChar,
  input  wire logic [fpd_pkg::UPPER_WIDTH-1:0] blinkUpper,
  input  wire logic [fpd_pkg::LOWER_WIDTH-1:0] blinkLower
);
  import fpd_pkg::*;

  if (NumKeys < 1) begin : g_check
    $error("fpd_display_cmd needs at least one panel key");
  end
  localparam int PinCount = NumKeys + 3;
  // pin synchronisers, first stage feeds only the second
  logic [PinCount-1:0] pinMeta_reg;
  logic [PinCount-1:0] pinSync_reg;
  logic [1:0]          localSeen_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pinMeta_reg   <= '0;
      pinSync_reg   <= '0;
      localSeen_reg <= 2'h0;
    end else begin
      pinMeta_reg   <= {panelKeys, outputOffKey, busGoToLocal, localKey};
      pinSync_reg   <= pinMeta_reg;
      localSeen_reg <= pinSync_reg[1:0];
    end
  end
  logic localKeyRise, busLocalRise;
  assign localKeyRise = pinSync_reg[0] & ~localSeen_reg[0];
  assign busLocalRise = pinSync_reg[1] & ~localSeen_reg[1];
  // apb: every transfer takes two access cycles so read data comes from a flop
  logic ack_reg;
  logic access, wrFire, rdCapture, addrHit;
  assign access    = psel & penable;
  assign pready    = access & ack_reg;
  assign wrFire    = pready & pwrite & addrHit;
  assign rdCapture = access & ~ack_reg & ~pwrite;
  assign addrHit   = (paddr == ADDR_CTRL) || (paddr == ADDR_DIGITS) ||
                     (paddr == ADDR_CMD) || (paddr == ADDR_TEXT_IN) ||
                     (paddr == ADDR_STATUS) || (paddr == ADDR_READ_SEL) ||
                     (paddr == ADDR_READ_DAT) || (paddr == ADDR_MSG_LEN);
  assign pslverr   = pready & ~addrHit;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end
  // one write strobe per writable register; ADDR_READ_DAT and ADDR_MSG_LEN have none
  logic wrCtrl, wrDigits, wrCmd, wrText, wrStatus, wrSel;
  assign wrCtrl   = wrFire && paddr == ADDR_CTRL;
  assign wrDigits = wrFire && paddr == ADDR_DIGITS;
  assign wrCmd    = wrFire && paddr == ADDR_CMD;
  assign wrText   = wrFire && paddr == ADDR_TEXT_IN;
  assign wrStatus = wrFire && paddr == ADDR_STATUS;
  assign wrSel    = wrFire && paddr == ADDR_READ_SEL;
  // any local request, from key, bus or serial command
  logic sysLocalCmd, localEvent;
  assign sysLocalCmd = wrCmd & pwdata[CMD_SYS_LOCAL];
  assign localEvent  = localKeyRise | busLocalRise | sysLocalCmd;
  // window index 0 or 1 is the upper line, 2 the lower, 3 is refused
  logic [1:0] winIdx;
  logic       winLine, winBad;
  assign winIdx  = pwdata[CMD_WIN_LSB +: 2];
  assign winLine = (winIdx == 2'h2);
  assign winBad  = (winIdx == 2'h3);
  // remote flag and display enable; local always wins over a write
  logic remote_reg, dispEn_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      remote_reg <= 1'b0;
      dispEn_reg <= RST_DISP_EN;
    end else if (localEvent) begin
      remote_reg <= 1'b0;
      dispEn_reg <= 1'b1;
    end else begin
      if (wrFire) begin
        remote_reg <= 1'b1;
      end
      if (wrCtrl) begin
        dispEn_reg <= pwdata[CTRL_DISP_EN];
      end
    end
  end
  // resolution: value is unsigned 4.4 fixed point, rounded half up
  logic [2:0]    digits_reg;
  logic [4:0]    digRounded;
  logic          digRangeOk;
  fpd_dig_kind_t digKind;
  assign digKind    = fpd_dig_kind_t'(pwdata[DIG_KIND_LSB +: 2]);
  assign digRounded = 5'((9'(pwdata[7:0]) + 9'h008) >> 4);
  assign digRangeOk = digRounded >= 5'(DIG_MIN) && digRounded <= 5'(DIG_MAX);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      digits_reg <= RST_DIGITS;
    end else if (wrDigits) begin
      case (digKind)
        DK_DEF: digits_reg <= DIG_DEF;
        DK_MIN: digits_reg <= DIG_MIN;
        DK_MAX: digits_reg <= DIG_MAX;
        DK_VALUE: begin
          if (digRangeOk) begin
            digits_reg <= digRounded[2:0];
          end
        end
        default: digits_reg <= digits_reg;
      endcase
    end
  end
  // message parser; one byte per write, bit 8 marks the end of the line
  fpd_parse_t pState_reg;
  logic [7:0] quote_reg, inByte;
  logic [1:0] digLeft_reg, textOn_reg;
  logic [6:0] lenTarget_reg, lenNext;
  logic [5:0] wrPos_reg, lenUp_reg, lenLo_reg, lineWidth;
  logic       msgLine_reg, inEol, isDigit, full;
  assign inByte    = pwdata[7:0];
  assign inEol     = pwdata[TEXT_EOL];
  assign isDigit   = inByte >= CH_ZERO && inByte <= CH_NINE;
  assign lenNext   = 7'(lenTarget_reg * 7'h0A + 7'(inByte - CH_ZERO));
  assign lineWidth = msgLine_reg ? 6'(LOWER_WIDTH) : 6'(UPPER_WIDTH);
  assign full      = wrPos_reg == lineWidth;
  // a storing byte goes straight into the message memory
  logic memWe;
  assign memWe = wrText && !inEol && !full &&
                 (pState_reg == PS_BODY || pState_reg == PS_INDEF ||
                  (pState_reg == PS_QUOTE && inByte != quote_reg));
  // parse outcome flags, consumed by the commit logic below
  logic pDone, pFail, lenFail;
  always_comb begin
    pDone   = 1'b0;
    pFail   = 1'b0;
    lenFail = 1'b0;
    if (wrText) begin
      case (pState_reg)
        PS_OPEN: begin
          pFail = inEol || !(inByte == CH_SQUOTE || inByte == CH_DQUOTE || inByte == CH_HASH);
        end
        PS_HASH: begin
          pFail = inEol || !(inByte == CH_ZERO || inByte == CH_ONE || inByte == CH_TWO);
        end
        PS_LEN: begin
          pFail   = inEol || !isDigit;
          lenFail = !pFail && digLeft_reg == 2'h1 && lenNext > 7'(lineWidth);
          pDone   = !pFail && !lenFail && digLeft_reg == 2'h1 && lenNext == 7'h00;
        end
        PS_QUOTE: begin
          pFail   = inEol;
          pDone   = !inEol && inByte == quote_reg;
          lenFail = !inEol && !pDone && full;
        end
        PS_BODY: begin
          pFail   = inEol;
          lenFail = !inEol && full;
          pDone   = !inEol && !full && 7'(wrPos_reg) + 7'h01 == lenTarget_reg;
        end
        PS_INDEF: begin
          // everything up to the line end is content, never a command
          pDone   = inEol;
          lenFail = !inEol && full;
        end
        default: pDone = 1'b0;
      endcase
    end
  end
  // parser state walk through the three message forms
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pState_reg    <= PS_IDLE;
      quote_reg     <= 8'h00;
      digLeft_reg   <= 2'h0;
      lenTarget_reg <= 7'h00;
      wrPos_reg     <= 6'h00;
      msgLine_reg   <= 1'b0;
    end else if (localEvent || pFail || lenFail || pDone) begin
      pState_reg <= PS_IDLE;
    end else if (wrCmd && pwdata[CMD_MSG_START] && !winBad) begin
      pState_reg  <= PS_OPEN;
      msgLine_reg <= winLine;
      wrPos_reg   <= 6'h00;
    end else if (wrText) begin
      case (pState_reg)
        PS_OPEN: begin
          quote_reg  <= inByte;
          pState_reg <= (inByte == CH_HASH) ? PS_HASH : PS_QUOTE;
        end
        PS_HASH: begin
          digLeft_reg   <= inByte[1:0];
          lenTarget_reg <= 7'h00;
          pState_reg    <= (inByte == CH_ZERO) ? PS_INDEF : PS_LEN;
        end
        PS_LEN: begin
          lenTarget_reg <= lenNext;
          digLeft_reg   <= digLeft_reg - 2'h1;
          if (digLeft_reg == 2'h1) begin
            pState_reg <= PS_BODY;
          end
        end
        PS_QUOTE, PS_BODY, PS_INDEF: begin
          wrPos_reg <= wrPos_reg + 6'h01; // spaces are counted like any byte
        end
        default: pState_reg <= PS_IDLE;
      endcase
    end
  end
  // stored lengths and text mode; local cancels both lines
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lenUp_reg  <= 6'h00;
      lenLo_reg  <= 6'h00;
      textOn_reg <= 2'b00;
    end else if (localEvent) begin
      lenUp_reg  <= 6'h00;
      lenLo_reg  <= 6'h00;
      textOn_reg <= 2'b00;
    end else begin
      if (pDone || pFail || lenFail) begin
        // a refused message leaves the line with no message at all
        if (msgLine_reg) begin
          lenLo_reg <= pDone ? (wrPos_reg + 6'(memWe)) : 6'h00;
        end else begin
          lenUp_reg <= pDone ? (wrPos_reg + 6'(memWe)) : 6'h00;
        end
      end
      if (wrCtrl) begin
        textOn_reg <= {pwdata[CTRL_TEXT_LO], pwdata[CTRL_TEXT_UP]};
      end
    end
  end
  // sticky errors: a new error in the clearing cycle survives
  logic digErr_reg, lenErr_reg, synErr_reg, digErrSet;
  assign digErrSet = wrDigits && digKind == DK_VALUE && !digRangeOk;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      digErr_reg <= 1'b0;
      lenErr_reg <= 1'b0;
      synErr_reg <= 1'b0;
    end else begin
      digErr_reg <= digErrSet | (digErr_reg & ~(wrStatus & pwdata[ST_DIG_ERR]));
      lenErr_reg <= lenFail | (lenErr_reg & ~(wrStatus & pwdata[ST_LEN_ERR]));
      synErr_reg <= pFail | (wrCmd & pwdata[CMD_MSG_START] & winBad) |
                    (synErr_reg & ~(wrStatus & pwdata[ST_SYN_ERR]));
    end
  end
  // readback selector and main view strobe
  logic [9:0] readSel_reg;
  logic       mainView_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      readSel_reg  <= 10'h000;
      mainView_reg <= 1'b0;
    end else begin
      mainView_reg <= wrCmd & pwdata[CMD_MAIN_VIEW];
      if (wrSel) begin
        readSel_reg <= {pwdata[SEL_DEFINED], pwdata[SEL_LINE], 3'h0, pwdata[4:0]};
      end
    end
  end
  assign returnMainView = mainView_reg;
  // selected line and position, also asked of the panel for its live character
  logic       selLine;
  logic [4:0] selPos;
  logic [7:0] memRdData;
  assign selLine = readSel_reg[SEL_LINE];
  assign selPos  = readSel_reg[4:0];
  assign liveLine = selLine;
  assign livePos  = selPos;
  fpd_msg_mem #(.Width(8), .Depth(64)) u_mem (
    .clock  (clock),
    .wrEn   (memWe),
    .wrAddr ({msgLine_reg, wrPos_reg[4:0]}),
    .wrData (inByte),
    .rdAddr ({selLine, selPos}),
    .rdData (memRdData)
  );
  // compose what the selected position shows and its blink flag
  logic [7:0] shownChar, blinkChar;
  logic       posValid, inMsg;
  always_comb begin
    posValid  = selLine ? 1'b1 : (selPos < 5'(UPPER_WIDTH));
    inMsg     = 6'(selPos) < (selLine ? lenLo_reg : lenUp_reg);
    shownChar = 8'h00;
    blinkChar = 8'h00;
    if (posValid) begin
      // ascii flag per position, leftmost position is index 0
      blinkChar = (selLine ? blinkLower[selPos] : blinkUpper[selPos]) ? CH_ONE
                                                                      : CH_ZERO;
      if (readSel_reg[SEL_DEFINED]) begin
        shownChar = inMsg ? memRdData : CH_SPACE;
      end else if (!dispEn_reg) begin
        shownChar = selLine ? NOTICE_LO[8*(LOWER_WIDTH-1-int'(selPos)) +: 8]
                            : NOTICE_UP[8*(UPPER_WIDTH-1-int'(selPos)) +: 8];
      end else if (textOn_reg[selLine]) begin
        shownChar = inMsg ? memRdData : CH_SPACE;
      end else begin
        shownChar = liveChar;
      end
    end
  end
  // read mux, captured in the first access cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rdCapture) begin
      case (paddr)
        ADDR_CTRL:     prdata <= {29'h0, textOn_reg, dispEn_reg};
        ADDR_DIGITS:   prdata <= {5'h0, DIG_MAX, 5'h0, DIG_MIN, 5'h0, DIG_DEF,
                                  5'h0, digits_reg};
        ADDR_STATUS:   prdata <= {25'h0, synErr_reg, lenErr_reg, digErr_reg, 2'h0,
                                  pState_reg != PS_IDLE, remote_reg};
        ADDR_READ_SEL: prdata <= {22'h0, readSel_reg};
        ADDR_READ_DAT: prdata <= {16'h0, blinkChar, shownChar};
        ADDR_MSG_LEN:  prdata <= {18'h0, lenLo_reg, 2'h0, lenUp_reg};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end
  // panel keys blocked while disabled; local and output-off always pass
  assign panelKeysOut = dispEn_reg ? pinSync_reg[PinCount-1:3] : '0;
  assign outputOffOut = pinSync_reg[2];
endmodule : fpd_display_cmd

// File: test/fpd_display_cmd_chk.sv
`timescale 1ns/1ps
// protocol and command checks seen from the block's pins only
module fpd_display_cmd_chk (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        outputOffKey,
  input wire logic        outputOffOut,
  input wire logic        returnMainView
);
  import fpd_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic       acc;
  logic       cmdMain;
  logic       mapped;
  logic [1:0] upCnt_reg;
  // completed transfer, main-view request and offset decode
  assign acc = psel && penable && pready;
  assign cmdMain = acc && pwrite && paddr == ADDR_CMD && pwdata[CMD_MAIN_VIEW];
  assign mapped = paddr[1:0] == 2'b00 && paddr <= ADDR_MSG_LEN;
  // cycles since reset; the key synchroniser needs two of history first
  always_ff @(posedge clock) begin
    if (!nrst) upCnt_reg <= 2'h0;
    else if (upCnt_reg != 2'h3) upCnt_reg <= upCnt_reg + 2'h1;
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  property p_one_wait;
    s_setup ##1 (psel && penable) |-> s_answer;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready not after one wait");
  property p_ready_qual;
    pready |-> psel && penable;
  endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("ready outside access");
  property p_err_decode;
    acc |-> pslverr == !mapped;
  endproperty
  a_err_decode: assert property (p_err_decode) else $error("wrong error response");
  property p_zero_read;
    acc && !pwrite && (!mapped || paddr == ADDR_CMD || paddr == ADDR_TEXT_IN) |-> prdata == 0;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("nonzero read of empty place");
  property p_dig_bounds;
    acc && !pwrite && paddr == ADDR_DIGITS |->
      prdata[31:8] == {5'h00, DIG_MAX, 5'h00, DIG_MIN, 5'h00, DIG_DEF};
  endproperty
  a_dig_bounds: assert property (p_dig_bounds) else $error("resolution bounds wrong");
  property p_main_pulse;
    cmdMain |=> returnMainView ##1 !returnMainView;
  endproperty
  a_main_pulse: assert property (p_main_pulse) else $error("main view pulse missing");
  property p_main_cause;
    $rose(returnMainView) |-> $past(cmdMain);
  endproperty
  a_main_cause: assert property (p_main_cause) else $error("main view pulse uncaused");
  property p_off_pass;
    upCnt_reg == 2'h3 |-> outputOffOut == $past(outputOffKey, 2);
  endproperty
  a_off_pass: assert property (p_off_pass) else $error("output off key not passed");
endmodule : fpd_display_cmd_chk

bind fpd_display_cmd fpd_display_cmd_chk fpd_display_cmd_chk_i (
  .clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .outputOffKey(outputOffKey), .outputOffOut(outputOffOut), .returnMainView(returnMainView)
);

// File: test/fpd_panel_model.sv
`timescale 1ns/1ps
// front panel stand-in: live character and blink flags for readback
module fpd_panel_model #(
  parameter logic [19:0] BlinkUp = 20'h80000,
  parameter logic [31:0] BlinkLo = 32'h0000_0020
) (
  input  wire logic        liveLine,
  input  wire logic [4:0]  livePos,
  output logic      [7:0]  liveChar,
  output logic      [19:0] blinkUpper,
  output logic      [31:0] blinkLower
);
  // same-cycle answer; lower case on the lower line so a line mix-up shows
  assign liveChar = (liveLine ? 8'h61 : 8'h41) + {3'h0, livePos};
  assign blinkUpper = BlinkUp;
  assign blinkLower = BlinkLo;
endmodule : fpd_panel_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fpd_pkg::*;
  logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, lastErr, localKey = 1'b0, busGoToLocal = 1'b0;
  logic        outputOffKey = 1'b0, outputOffOut, returnMainView, liveLine;
  logic [7:0]  panelKeys = 8'h00, panelKeysOut, liveChar;
  logic [4:0]  livePos;
  logic [19:0] blinkUpper;
  logic [31:0] blinkLower;
  int          err_count = 0, n_checks = 0;
  string       msgs[7] = '{"'ABCDEFGHIJKLMNOPQRSTU'", "'A B'", "\"AB\"",
    "#220ABCDEFGHIJKLMNOPQRST", "#14WXYZ", "#232ABCDEFGHIJKLMNOPQRSTUVWXYZ012345",
    "#233ABCDEFGHIJKLMNOPQRSTUVWXYZ0123456"};
  logic [31:0] mExp[7] = '{0, 3, 2, 32'h14, 4, 32'h2000, 0};
  logic [31:0] dIn[8] = '{32'h48, 32'h3F, 32'h77, 32'h80, 32'h37, 32'h100, 32'h200, 32'h300};
  logic [31:0] dExp[8] = '{5, 4, 7, 7, 7, 6, 4, 7};
  logic [31:0] sel[5] = '{32'h105, 32'h005, 32'h013, 32'h014, 32'h11F};
  logic [31:0] sExp[5] = '{32'h3166, 32'h3046, 32'h3154, 0, 32'h3080};

  always #2.5 clock = ~clock;

  fpd_display_cmd fpd_display_cmd_i (
    .clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .localKey(localKey), .busGoToLocal(busGoToLocal), .outputOffKey(outputOffKey),
    .panelKeys(panelKeys), .panelKeysOut(panelKeysOut), .outputOffOut(outputOffOut),
    .returnMainView(returnMainView), .liveLine(liveLine), .livePos(livePos),
    .liveChar(liveChar), .blinkUpper(blinkUpper), .blinkLower(blinkLower));
  fpd_panel_model fpd_panel_model_i (
    .liveLine(liveLine), .livePos(livePos), .liveChar(liveChar),
    .blinkUpper(blinkUpper), .blinkLower(blinkLower));

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one transfer; request held until ready is sampled, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("ready wait", 0, 1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(name, r & m, e);
  endtask : rdc

  task automatic txt(input string s);
    for (int i = 0; i < s.len(); i++) wr(ADDR_TEXT_IN, {24'h0, s[i]});
  endtask : txt

  // pin events go through a two-stage synchroniser, so hold and settle
  task automatic evt(input int k);
    if (k == 0) localKey <= 1'b1;
    else busGoToLocal <= 1'b1;
    repeat (4) @(posedge clock);
    localKey <= 1'b0;
    busGoToLocal <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : evt

  // watchdog sized well past the whole sequence
  initial begin
    repeat (20000) @(posedge clock);
    check("watchdog", 0, 1);
    complete_run();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdc("ctrl", ADDR_CTRL, 32'h7, 32'h1);
    rdc("digits", ADDR_DIGITS, '1, 32'h0704_0606);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_DIGITS, dIn[i]);
      rdc("digits code", ADDR_DIGITS, 32'hFF, dExp[i]);
    end
    rdc("resolution err", ADDR_STATUS, 32'h10, 32'h10);
    wr(ADDR_STATUS, 32'h70);
    panelKeys <= 8'hA5;
    outputOffKey <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
    rdc("ctrl off", ADDR_CTRL, 32'h1, 32'h0);
    check("keys blocked", {24'h0, panelKeysOut}, 32'h0);
    check("output off key", {31'h0, outputOffOut}, 32'h1);
    wr(ADDR_READ_SEL, 32'h0);
    rdc("notice", ADDR_READ_DAT, 32'hFF, {24'h0, NOTICE_UP[8*UPPER_WIDTH-1 -: 8]});
    evt(0);
    rdc("ctrl local", ADDR_CTRL, 32'h1, 32'h1);
    check("keys pass", {24'h0, panelKeysOut}, 32'hA5);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_READ_SEL, sel[i]);
      rdc("live char", ADDR_READ_DAT, 32'hFFFF, sExp[i]);
    end
    wr(ADDR_CMD, 32'h1);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CMD, i < 5 ? 32'h4 : 32'h204);
      txt(msgs[i]);
      rdc("msg len", ADDR_MSG_LEN, i < 5 ? 32'h3F : 32'h3F00, mExp[i]);
    end
    rdc("length err", ADDR_STATUS, 32'h20, 32'h20);
    wr(ADDR_CTRL, 32'h3);
    wr(ADDR_READ_SEL, 32'h1);
    rdc("text shown", ADDR_READ_DAT, 32'hFF, 32'h58);
    wr(ADDR_READ_SEL, 32'h202);
    rdc("text defined", ADDR_READ_DAT, 32'hFF, 32'h59);
    rdc("text mode", ADDR_CTRL, 32'h7, 32'h3);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_READ_SEL, 32'h1);
    rdc("text removed", ADDR_READ_DAT, 32'hFF, 32'h42);
    wr(ADDR_CMD, 32'h204);
    txt("#0AB;X");
    wr(ADDR_TEXT_IN, 32'h100);
    rdc("indefinite len", ADDR_MSG_LEN, 32'h3F00, 32'h0400);
    wr(ADDR_STATUS, 32'h70);
    wr(ADDR_CMD, 32'h304);
    rdc("bad window", ADDR_STATUS, 32'h40, 32'h40);
    wr(ADDR_STATUS, 32'h70);
    wr(ADDR_CMD, 32'h4);
    txt("'A");
    wr(ADDR_TEXT_IN, 32'h100);
    rdc("eol in quote", ADDR_STATUS, 32'h40, 32'h40);
    rdc("refused len", ADDR_MSG_LEN, 32'h3F, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CMD, 32'h104);
      txt("'OK'");
      wr(ADDR_CTRL, 32'h7);
      rdc("remote", ADDR_STATUS, 32'h1, 32'h1);
      if (k == 2) wr(ADDR_CMD, 32'h2);
      else evt(k);
      rdc("local len", ADDR_MSG_LEN, 32'h3F3F, 32'h0);
      rdc("local ctrl", ADDR_CTRL, 32'h7, 32'h1);
      rdc("local remote", ADDR_STATUS, 32'h1, 32'h0);
    end
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped err", {31'h0, lastErr}, 32'h1);
    check("unmapped data", r, 32'h0);
    complete_run();
  end
endmodule : testbench
